/* rtl/qac_pkg.sv */
package qac_pkg;

    // Configuration byte layout
    localparam int CFG_SEL_HI = 7;
    localparam int CFG_SEL_LO = 4;
    localparam int CFG_REF_BIT = 3;
    localparam int CFG_FILT_BIT = 2;
    localparam int CFG_TRIAL_BIT = 1;
    localparam int CFG_SAMPLE_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'hF0;

    // Channel masks
    localparam logic [3:0] SEL_ALL = 4'hF;
    localparam logic [3:0] SEL_NO_IN3 = 4'h7;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [1:0] CHAN_TOP = 2'h3;

    // Result word
    localparam int WORD_W = 16;
    localparam int DATA_W = 12;
    localparam logic [DATA_W-1:0] DATA_ONES = 12'hFFF;
    localparam logic [1:0] LEAD_ZEROS = 2'h0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam int FIFO_DEPTH = 16;

    // Serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] FIRST_BIT = 4'h1;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic PIN_LOW = 1'b0;
    localparam logic LINE_IDLE = 1'b1;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILT_NS = 50;
    localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUIET_NS = 100;
    localparam int QUIET_CYC =
        (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] FILT_LAST = 3'(FILT_CYC - 1);
    localparam logic [2:0] QUIET_LOAD = 3'(QUIET_CYC);
    localparam logic [2:0] CNT_ZERO = 3'h0;

    typedef enum logic [2:0] {
        QAC_IDLE,
        QAC_ADDR,
        QAC_ADDR_ACK,
        QAC_WR_DATA,
        QAC_WR_ACK,
        QAC_RD_LOAD,
        QAC_RD_DATA,
        QAC_RD_ACK
    } qac_state_e;

endpackage

/* rtl/qac_fifo.sv */
`timescale 1ns/1ps
module qac_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE_CNT = (AW+1)'(1);
    localparam logic [AW-1:0] ONE_PTR = AW'(1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW-1:0] rd_next;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q != FULL_CNT;
    assign out_valid = cnt_q != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign rd_next = pop ? rd_ptr_q + ONE_PTR : rd_ptr_q;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Registered head word, with bypass of a same-slot write
    always_ff @(posedge clk) begin
        if (push && wr_ptr_q == rd_next) begin
            out_data <= in_data;
        end else begin
            out_data <= mem_q[rd_next];
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            rd_ptr_q <= rd_next;
            if (push) begin
                wr_ptr_q <= wr_ptr_q + ONE_PTR;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + ONE_CNT;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - ONE_CNT;
            end
        end
    end

endmodule // qac_fifo

/* rtl/qac_ctrl.sv */
`timescale 1ns/1ps
module qac_ctrl
    import qac_pkg::*;
#(
    parameter logic [6:0] dev_addr = 7'h29,
    parameter int res_bits = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial clock line, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // Serial data line, open drain
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Converter core
    output logic conv_start,
    output logic [1:0] conv_chan,
    output logic input_three_or_ext_reference,
    output logic sample_hold,
    output logic bit_trial_hold,
    input wire logic conv_done,
    input wire logic [DATA_W-1:0] conv_data,
    output logic conv_ready
);

    // Next enabled channel above cur, wrapping
    function automatic logic [1:0] next_sel(input logic [3:0] mask,
                                            input logic [1:0] cur);
        logic [1:0] idx;
        logic [1:0] nxt;
        logic found;
        idx = cur;
        nxt = cur;
        found = 1'b0;
        for (int k = 0; k < 4; k++) begin
            idx = idx + 2'h1;
            if (mask[idx] && !found) begin
                nxt = idx;
                found = 1'b1;
            end
        end
        return nxt;
    endfunction

    // Zero the bits below the build resolution
    function automatic logic [DATA_W-1:0] trim_result(
            input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] m;
        m = DATA_ONES << (DATA_W - res_bits);
        return d & m;
    endfunction

    logic [7:0] cfg_q;
    logic [2:0] sync_q [2];
    logic [2:0] filt_cnt_q [2];
    logic [1:0] line_q;
    logic [1:0] prev_q;
    logic [1:0] pins;
    logic [2:0] quiet_q;
    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic bus_busy;
    logic filt_bypass;

    qac_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [WORD_W-1:0] word_q;
    logic rw_q;
    logic first_wr_q;
    logic byte_hi_q;
    logic acked_q;
    logic sda_oe_q;
    logic scl_oe_q;

    logic [3:0] sel_eff;
    logic req_first;
    logic req_next;
    logic conv_pend_q;
    logic conv_start_q;
    logic [1:0] chan_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [WORD_W-1:0] fifo_out_data;
    logic [WORD_W-1:0] push_word;

    assign pins = {sda_i, scl_i};
    assign scl_f = line_q[0];
    assign sda_f = line_q[1];
    assign filt_bypass = cfg_q[CFG_FILT_BIT];
    assign scl_rise = scl_f && !prev_q[0];
    assign scl_fall = !scl_f && prev_q[0];
    assign start_seen = scl_f && prev_q[0] && !sda_f && prev_q[1];
    assign stop_seen = scl_f && prev_q[0] && sda_f && !prev_q[1];

    // Line sampling, three stages, with optional glitch filter
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                sync_q[i] <= {3{LINE_IDLE}};
                filt_cnt_q[i] <= CNT_ZERO;
            end
            line_q <= {2{LINE_IDLE}};
            prev_q <= {2{LINE_IDLE}};
        end else begin
            prev_q <= line_q;
            for (int i = 0; i < 2; i++) begin
                sync_q[i] <= {sync_q[i][1:0], pins[i]};
                if (sync_q[i][1] != sync_q[i][2] ||
                    sync_q[i][2] == line_q[i]) begin
                    filt_cnt_q[i] <= CNT_ZERO;
                end else if (filt_bypass ||
                             filt_cnt_q[i] == FILT_LAST) begin
                    line_q[i] <= sync_q[i][2];
                    filt_cnt_q[i] <= CNT_ZERO;
                end else begin
                    filt_cnt_q[i] <= filt_cnt_q[i] + 3'h1;
                end
            end
        end
    end

    // Bus activity window for the hold-offs
    always_ff @(posedge clk) begin
        if (rst) begin
            quiet_q <= CNT_ZERO;
        end else if (line_q != prev_q) begin
            quiet_q <= QUIET_LOAD;
        end else if (quiet_q != CNT_ZERO) begin
            quiet_q <= quiet_q - 3'h1;
        end
    end

    assign bus_busy = quiet_q != CNT_ZERO;
    assign sample_hold = bus_busy && !cfg_q[CFG_SAMPLE_BIT];
    assign bit_trial_hold = bus_busy && !cfg_q[CFG_TRIAL_BIT];
    assign input_three_or_ext_reference = cfg_q[CFG_REF_BIT];

    // Serial slave sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= QAC_IDLE;
            bit_cnt_q <= BIT_ZERO;
            shift_q <= '0;
            tx_q <= '0;
            word_q <= WORD_ZERO;
            rw_q <= 1'b0;
            first_wr_q <= 1'b0;
            byte_hi_q <= 1'b1;
            acked_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            cfg_q <= CFG_RESET;
        end else if (start_seen) begin
            state_q <= QAC_ADDR;
            bit_cnt_q <= BIT_ZERO;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else if (stop_seen) begin
            state_q <= QAC_IDLE;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else begin
            case (state_q)
                QAC_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                QAC_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
                        if (shift_q[7:1] == dev_addr) begin
                            sda_oe_q <= 1'b1;
                            rw_q <= shift_q[0];
                            state_q <= QAC_ADDR_ACK;
                        end else begin
                            state_q <= QAC_IDLE;
                        end
                    end
                end
                QAC_ADDR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        bit_cnt_q <= BIT_ZERO;
                        first_wr_q <= 1'b1;
                        byte_hi_q <= 1'b1;
                        state_q <= rw_q ? QAC_RD_LOAD : QAC_WR_DATA;
                    end
                end
                QAC_WR_DATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
                        if (first_wr_q) begin
                            cfg_q <= shift_q;
                            sda_oe_q <= 1'b1;
                        end
                        first_wr_q <= 1'b0;
                        state_q <= QAC_WR_ACK;
                    end
                end
                QAC_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        bit_cnt_q <= BIT_ZERO;
                        state_q <= QAC_WR_DATA;
                    end
                end
                QAC_RD_LOAD: begin
                    if (fifo_out_valid || !conv_pend_q) begin
                        word_q <= fifo_out_valid ? fifo_out_data : WORD_ZERO;
                        tx_q <= fifo_out_valid ? fifo_out_data[15:8]
                                               : WORD_ZERO[15:8];
                        sda_oe_q <= fifo_out_valid ? !fifo_out_data[15]
                                                   : 1'b1;
                        bit_cnt_q <= FIRST_BIT;
                        scl_oe_q <= 1'b0;
                        state_q <= QAC_RD_DATA;
                    end else begin
                        scl_oe_q <= 1'b1;
                    end
                end
                QAC_RD_DATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == BITS_PER_BYTE) begin
                            sda_oe_q <= 1'b0;
                            state_q <= QAC_RD_ACK;
                        end else begin
                            tx_q <= {tx_q[6:0], PIN_LOW};
                            sda_oe_q <= !tx_q[6];
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                QAC_RD_ACK: begin
                    if (scl_rise) begin
                        acked_q <= !sda_f;
                    end else if (scl_fall) begin
                        if (!acked_q) begin
                            state_q <= QAC_IDLE;
                        end else if (byte_hi_q) begin
                            byte_hi_q <= 1'b0;
                            tx_q <= word_q[7:0];
                            sda_oe_q <= !word_q[7];
                            bit_cnt_q <= FIRST_BIT;
                            state_q <= QAC_RD_DATA;
                        end else begin
                            byte_hi_q <= 1'b1;
                            state_q <= QAC_RD_LOAD;
                        end
                    end
                end
                default: begin
                    state_q <= QAC_IDLE;
                end
            endcase
        end
    end

    assign sda_oe = sda_oe_q;
    assign sda_o = PIN_LOW;
    assign scl_oe = scl_oe_q;
    assign scl_o = PIN_LOW;
    assign fifo_pop = (state_q == QAC_RD_LOAD) && !start_seen && !stop_seen;

    // Conversion requests
    assign sel_eff = cfg_q[CFG_SEL_HI:CFG_SEL_LO] &
                     (cfg_q[CFG_REF_BIT] ? SEL_NO_IN3 : SEL_ALL);
    assign req_first = (state_q == QAC_ADDR_ACK) && scl_rise && rw_q &&
                       !start_seen && !stop_seen;
    assign req_next = (state_q == QAC_RD_ACK) && scl_rise && !sda_f &&
                      !byte_hi_q && !start_seen && !stop_seen;

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_start_q <= 1'b0;
            chan_q <= 2'h0;
            conv_pend_q <= 1'b0;
        end else begin
            conv_start_q <= 1'b0;
            if ((req_first || req_next) &&
                sel_eff != SEL_NONE) begin
                conv_start_q <= 1'b1;
                conv_pend_q <= 1'b1;
                chan_q <= req_first ? next_sel(sel_eff, CHAN_TOP)
                                    : next_sel(sel_eff, chan_q);
            end else if (conv_done && fifo_in_ready) begin
                conv_pend_q <= 1'b0;
            end
        end
    end

    assign conv_start = conv_start_q;
    assign conv_chan = chan_q;
    assign conv_ready = fifo_in_ready;
    assign push_word = {LEAD_ZEROS, chan_q,
                        trim_result(conv_data)};

    qac_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(conv_done),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

endmodule // qac_ctrl

/* verif/qac_ctrl_properties.sv */
`timescale 1ns/1ps
module qac_ctrl_chk
    import qac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus pins
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Converter side
    input wire logic conv_start,
    input wire logic [1:0] conv_chan,
    input wire logic sample_hold,
    input wire logic bit_trial_hold
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [4:0] quiet_q;
    // Cycles since the last raw bus edge
    always_ff @(posedge clk) begin
        if (rst || $changed(scl_i) || $changed(sda_i)) begin
            quiet_q <= 5'h00;
        end else if (quiet_q != 5'h1F) begin
            quiet_q <= quiet_q + 5'h01;
        end
    end
    a_start_gap: assert property (
        conv_start |=> !conv_start [*8])
        else $error("conversion start repeated too soon");
    a_drive_zero: assert property (
        !scl_o && !sda_o)
        else $error("open drain value not low");
    a_sample_quiet: assert property (
        quiet_q >= 5'h10 |-> !sample_hold)
        else $error("sample hold on a quiet bus");
    a_trial_quiet: assert property (
        quiet_q >= 5'h10 |-> !bit_trial_hold)
        else $error("bit trial hold on a quiet bus");
    a_sda_clk_low: assert property (
        $changed(sda_oe) |-> !$past(scl_i))
        else $error("data changed while clock high");
    a_stretch_low: assert property (
        $rose(scl_oe) |-> !scl_i)
        else $error("stretch began while clock high");
    a_chan_moves: assert property (
        $changed(conv_chan) |-> conv_start || $past(conv_start))
        else $error("channel changed without a start");
    a_start_free: assert property (
        conv_start |-> !scl_oe)
        else $error("start issued while stretching");
    c_start: cover property (conv_start);
    c_stretch: cover property ($rose(scl_oe));
    c_hold: cover property (sample_hold);
endmodule // qac_ctrl_chk

bind qac_ctrl qac_ctrl_chk u_chk (
    .clk(clk), .rst(rst), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .conv_start(conv_start), .conv_chan(conv_chan),
    .sample_hold(sample_hold), .bit_trial_hold(bit_trial_hold)
);

/* verif/qac_master.sv */
`timescale 1ns/1ps
module qac_master #(
    parameter int LO = 14,
    parameter int HI = 6
) (
    // Clock and wire levels
    input wire logic clk,
    input wire logic scl_w,
    input wire logic sda_w,
    // Open drain drives, 1 releases
    output logic scl_m,
    output logic sda_m
);
    int tmo = 0;
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One clock pulse, sampled at the end of high
    task automatic pulse(input logic d, output logic q);
        int k;
        cyc(LO / 2);
        sda_m = d;
        cyc(LO - LO / 2);
        scl_m = 1'b1;
        k = 0;
        while (scl_w !== 1'b1 && k < 5000) begin
            cyc(1);
            k++;
        end
        if (k == 5000) tmo++;
        cyc(HI);
        q = sda_w;
        scl_m = 1'b0;
    endtask
    // Short clock pulse of n cycles inside a low phase
    task automatic glitch(input int n);
        cyc(LO / 2);
        scl_m = 1'b1;
        cyc(n);
        scl_m = 1'b0;
    endtask
    task automatic start();
        cyc(LO / 2);
        sda_m = 1'b1;
        cyc(LO / 2);
        scl_m = 1'b1;
        cyc(HI);
        sda_m = 1'b0;
        cyc(HI);
        scl_m = 1'b0;
    endtask
    task automatic stop();
        cyc(LO / 2);
        sda_m = 1'b0;
        cyc(LO / 2);
        scl_m = 1'b1;
        cyc(HI);
        sda_m = 1'b1;
        cyc(HI);
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) pulse(b[i], q);
        pulse(1'b1, q);
        ack = ~q;
    endtask
    task automatic get(input logic ack, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, q);
            b[i] = q;
        end
        pulse(~ack, q);
    endtask
endmodule // qac_master

/* verif/quad_adc_i2c_slave_control_test.sv */
`timescale 1ns/1ps
module quad_adc_i2c_slave_control_test import qac_pkg::*;;
    localparam logic [6:0] ADDR = 7'h29;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic conv_done = 1'b0;
    logic [DATA_W-1:0] conv_data = 12'h000;
    logic taken = 1'b0;
    logic hold_seen = 1'b0;
    logic scl_m, sda_m, scl_oe, sda_oe, conv_start, conv_ready, a;
    logic sample_hold, bit_trial_hold, ref_out;
    logic [1:0] conv_chan;
    logic [7:0] b;
    wire scl_w = scl_m & ~scl_oe;
    wire sda_w = sda_m & ~sda_oe;
    int error_cnt = 0;
    int total_checks = 0;
    int starts = 0;
    int cwait = 0;
    always #10 clk = ~clk;
    qac_ctrl #(.dev_addr(ADDR), .res_bits(12)) DUT (
        .clk(clk), .rst(rst), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .conv_start(conv_start),
        .conv_chan(conv_chan), .input_three_or_ext_reference(ref_out),
        .sample_hold(sample_hold), .bit_trial_hold(bit_trial_hold),
        .conv_done(conv_done), .conv_data(conv_data),
        .conv_ready(conv_ready)
    );
    qac_master m (.clk(clk), .scl_w(scl_w), .sda_w(sda_w),
        .scl_m(scl_m), .sda_m(sda_m));
    function automatic logic [11:0] dat(input logic [1:0] c);
        return 12'hA3C ^ {6{c}};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Read n words; seq holds expected tags, first in the low bits
    task automatic rd(input int n, input logic [7:0] seq);
        logic ak;
        logic [7:0] hi, lo;
        logic [1:0] ch;
        m.start();
        m.put({ADDR, 1'b1}, ak);
        chk(ak, 1'b1);
        for (int i = 0; i < n; i++) begin
            ch = seq[2*i +: 2];
            m.get(1'b1, hi);
            m.get(i < n - 1, lo);
            chk({hi, lo}, {2'b00, ch, dat(ch)});
        end
        m.stop();
    endtask
    task automatic wr(input logic [7:0] v);
        logic ak;
        m.start();
        m.put({ADDR, 1'b0}, ak);
        chk(ak, 1'b1);
        m.put(v, ak);
        chk(ak, 1'b1);
        m.stop();
    endtask
    // Converter core, result 10 cycles after a start
    always @(negedge clk) begin
        if (taken) conv_done = 1'b0;
        if (conv_start === 1'b1) begin
            starts++;
            cwait = 10;
        end else if (cwait == 1) begin
            conv_done = 1'b1;
            conv_data = dat(conv_chan);
            cwait = 0;
        end else if (cwait > 1) begin
            cwait--;
        end
    end
    always @(posedge clk) begin
        taken <= conv_done & conv_ready;
        if (sample_hold === 1'b1 || bit_trial_hold === 1'b1) hold_seen = 1;
        if (m.tmo != 0) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(ref_out, 1'b0);
        chk(conv_ready, 1'b1);
        m.start();
        m.glitch(2);
        m.put({ADDR, 1'b0}, a);
        m.stop();
        chk(a, 1'b1);
        rd(4, 8'hE4);
        chk(16'(starts), 16'h0004);
        chk(hold_seen, 1'b1);
        wr(8'h50);
        rd(3, 8'h08);
        wr(8'hF8);
        chk(ref_out, 1'b1);
        rd(4, 8'h24);
        wr(8'hF3);
        hold_seen = 1'b0;
        rd(2, 8'h04);
        chk(hold_seen, 1'b0);
        wr(8'hF4);
        rd(2, 8'h04);
        m.start();
        m.glitch(2);
        m.put({ADDR, 1'b0}, a);
        m.stop();
        chk(a, 1'b0);
        wr(8'h00);
        starts = 0;
        m.start();
        m.put({ADDR, 1'b1}, a);
        m.get(1'b1, b);
        chk(b, 8'h00);
        m.get(1'b0, b);
        m.stop();
        chk({b, starts[7:0]}, 16'h0000);
        m.start();
        m.put({ADDR ^ 7'h01, 1'b1}, a);
        m.stop();
        chk(a, 1'b0);
        m.start();
        m.put({ADDR, 1'b0}, a);
        m.put(8'h10, a);
        chk(a, 1'b1);
        m.put(8'hF0, a);
        chk(a, 1'b0);
        m.stop();
        rd(2, 8'h00);
        give_verdict();
    end
endmodule // quad_adc_i2c_slave_control_test
